// ### logic/adcc_pkg.sv
// Package: register map, field layout, states and carriers of the converter control
package adcc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_SC1 = 8'h00;
    localparam logic [7:0] ADDR_SC2 = 8'h04;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
    localparam logic [7:0] ADDR_CMP_HIGH = 8'h10;
    localparam logic [7:0] ADDR_CMP_LOW = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

    // First status/control register fields
    localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
    localparam int SC1_COMPLETE_IRQ_ENABLE_BIT = 6;
    localparam int SC1_CONT_BIT = 5;
    localparam int SC1_CHAN_MSB = 4;

    // Second status/control register fields
    localparam int SC2_ACTIVE_BIT = 7;
    localparam int SC2_TRG_BIT = 6;
    localparam int SC2_CMPEN_BIT = 5;
    localparam int SC2_CMPGT_BIT = 4;

    // Channel codes
    localparam logic [4:0] CHAN_LAST_INPUT = 5'h1b;
    localparam logic [4:0] CHAN_RESERVED = 5'h1c;
    localparam logic [4:0] CHAN_HIGH_REF = 5'h1d;
    localparam logic [4:0] CHAN_LOW_REF = 5'h1e;
    localparam logic [4:0] CHAN_DISABLED = 5'h1f;
    localparam logic [4:0] CHAN_RESET = 5'h1f;

    // Widths and reset values
    localparam int RES_W = 10;
    localparam int NUM_INPUTS = 28;
    localparam int IRQ_W = 2;
    localparam int IRQ_EV_COMPLETE = 0;
    localparam int IRQ_EV_ABORT = 1;
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [RES_W-1:0] CMP_RESET = 10'h000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } adcc_state_t;

    // Analog input routing
    typedef struct packed {
        logic [NUM_INPUTS-1:0] inputs;
        logic high_ref;
        logic low_ref;
        logic isolate;
    } adcc_route_t;

    // Commands to the analog converter core
    typedef struct packed {
        logic start;
        logic abort;
        logic power_en;
        logic [4:0] channel;
    } adcc_conv_ctl_t;

    // Answer from the analog converter core
    typedef struct packed {
        logic done;
        logic [RES_W-1:0] data;
    } adcc_conv_res_t;

    // Whole state of the control block
    typedef struct packed {
        adcc_state_t st;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic conversion_complete_flag;
        logic complete_irq_enable;
        logic cont;
        logic [4:0] chan;
        logic trg;
        logic cmp_en;
        logic cmp_gt;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] cmp_val;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic trig_s1;
        logic trig_s2;
        logic trig_s3;
        logic start;
        logic abort;
        logic conv_irq;
        logic irq;
        adcc_route_t route;
    } adcc_regs_t;

endpackage

// ### logic/adcc_top.sv
// Conversion control, status, interrupt and register slave of the analog converter
`timescale 1ns/100ps

module adcc_top (
    input wire logic aclk, // Clock, 25 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [7:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic hardware_trigger_input, // Hardware start trigger pin
    input adcc_pkg::adcc_conv_res_t conv_res, // Answer of the converter core
    output adcc_pkg::adcc_conv_ctl_t conv_ctl, // Commands to the converter core
    output adcc_pkg::adcc_route_t route, // Analog input routing
    output logic conv_irq, // Conversion complete interrupt request
    output logic irq // Masked event interrupt
);

    adcc_pkg::adcc_regs_t q;
    adcc_pkg::adcc_regs_t d;

    logic hw_edge;
    logic wr_fire;
    logic rd_fire;
    logic sc1_wr;
    logic conv_done;
    logic cmp_true;
    logic accept;
    logic conversion_complete_flag_set;
    logic conversion_complete_flag_clr;
    logic abort_ev;
    logic hw_start;
    logic [4:0] new_chan;
    logic [adcc_pkg::IRQ_W-1:0] irq_w1c;
    logic [adcc_pkg::IRQ_W-1:0] irq_ev;

    // Channel decode into input routing
    function automatic adcc_pkg::adcc_route_t decode_chan(input logic [4:0] ch);
        adcc_pkg::adcc_route_t r;
        r = '0;
        if (ch <= adcc_pkg::CHAN_LAST_INPUT) begin
            r.inputs[ch] = 1'b1;
        end else if (ch == adcc_pkg::CHAN_HIGH_REF) begin
            r.high_ref = 1'b1;
        end else if (ch == adcc_pkg::CHAN_LOW_REF) begin
            r.low_ref = 1'b1;
        end else begin
            r.isolate = 1'b1;
        end
        return r;
    endfunction

    assign awready = ~q.aw_got;
    assign wready = ~q.w_got;
    assign arready = ~q.rvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = {24'h000000, q.rdata};
    assign conv_ctl.start = q.start;
    assign conv_ctl.abort = q.abort;
    assign conv_ctl.power_en = (q.st == adcc_pkg::ST_CONV);
    assign conv_ctl.channel = q.chan;
    assign route = q.route;
    assign conv_irq = q.conv_irq;
    assign irq = q.irq;

    always_comb begin
        d = q;
        hw_edge = 1'b0;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        sc1_wr = 1'b0;
        conv_done = 1'b0;
        cmp_true = 1'b0;
        accept = 1'b0;
        conversion_complete_flag_set = 1'b0;
        conversion_complete_flag_clr = 1'b0;
        abort_ev = 1'b0;
        hw_start = 1'b0;
        new_chan = q.chan;
        irq_w1c = '0;
        irq_ev = '0;
        d.start = 1'b0;
        d.abort = 1'b0;

        // Trigger pin synchroniser and rising edge
        d.trig_s1 = hardware_trigger_input;
        d.trig_s2 = q.trig_s1;
        d.trig_s3 = q.trig_s2;
        hw_edge = q.trig_s2 & ~q.trig_s3;

        // Write address and data taken in either order
        if (awvalid && ~q.aw_got) begin
            d.aw_got = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && ~q.w_got) begin
            d.w_got = 1'b1;
            d.w_data = wdata[7:0];
            d.w_lane0 = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        wr_fire = q.aw_got & q.w_got & ~q.bvalid;

        // Conversion end and compare
        conv_done = (q.st == adcc_pkg::ST_CONV) && conv_res.done;
        if (q.cmp_gt) begin
            cmp_true = (conv_res.data >= q.cmp_val);
        end else begin
            cmp_true = (conv_res.data < q.cmp_val);
        end
        accept = conv_done & (~q.cmp_en | cmp_true);
        conversion_complete_flag_set = accept;
        if (accept) begin
            d.result = conv_res.data;
        end
        if (conv_done) begin
            if (q.cont && q.chan != adcc_pkg::CHAN_DISABLED) begin
                d.start = 1'b1;
            end else begin
                d.st = adcc_pkg::ST_IDLE;
            end
        end

        // hardware start only on trigger edge
        hw_start = q.trg & hw_edge & (q.st == adcc_pkg::ST_IDLE)
            & (q.chan != adcc_pkg::CHAN_DISABLED);
        if (hw_start) begin
            d.st = adcc_pkg::ST_CONV;
            d.start = 1'b1;
        end

        // Register writes
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = adcc_pkg::RESP_OKAY;
            case (q.aw_addr)
                adcc_pkg::ADDR_SC1: sc1_wr = q.w_lane0;
                adcc_pkg::ADDR_SC2: begin
                    if (q.w_lane0) begin
                        d.trg = q.w_data[adcc_pkg::SC2_TRG_BIT];
                        d.cmp_en = q.w_data[adcc_pkg::SC2_CMPEN_BIT];
                        d.cmp_gt = q.w_data[adcc_pkg::SC2_CMPGT_BIT];
                    end
                end
                adcc_pkg::ADDR_RES_HIGH: ;
                adcc_pkg::ADDR_RES_LOW: ;
                adcc_pkg::ADDR_CMP_HIGH: begin
                    if (q.w_lane0) begin
                        d.cmp_val[adcc_pkg::RES_W-1:8] = q.w_data[1:0];
                    end
                end
                adcc_pkg::ADDR_CMP_LOW: begin
                    if (q.w_lane0) begin
                        d.cmp_val[7:0] = q.w_data;
                    end
                end
                adcc_pkg::ADDR_IRQ_STATUS: begin
                    if (q.w_lane0) begin
                        irq_w1c = q.w_data[adcc_pkg::IRQ_W-1:0];
                    end
                end
                adcc_pkg::ADDR_IRQ_MASK: begin
                    if (q.w_lane0) begin
                        d.irq_mask = q.w_data[adcc_pkg::IRQ_W-1:0];
                    end
                end
                default: d.bresp = adcc_pkg::RESP_SLVERR;
            endcase
        end

        if (sc1_wr) begin
            new_chan = q.w_data[adcc_pkg::SC1_CHAN_MSB:0];
            d.complete_irq_enable = q.w_data[adcc_pkg::SC1_COMPLETE_IRQ_ENABLE_BIT];
            d.cont = q.w_data[adcc_pkg::SC1_CONT_BIT];
            d.chan = new_chan;
            conversion_complete_flag_clr = 1'b1;
            if (q.st == adcc_pkg::ST_CONV && !conv_done) begin
                d.abort = 1'b1;
                abort_ev = 1'b1;
            end
            d.st = adcc_pkg::ST_IDLE;
            d.start = 1'b0;
            if (new_chan != adcc_pkg::CHAN_DISABLED && !q.trg) begin
                d.st = adcc_pkg::ST_CONV;
                d.start = 1'b1;
            end
            if (new_chan == adcc_pkg::CHAN_DISABLED) begin
                d.start = 1'b0;
            end
        end
        d.route = decode_chan(d.chan);

        // Register reads
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        rd_fire = arvalid & ~q.rvalid;
        if (rd_fire) begin
            d.rvalid = 1'b1;
            d.rresp = adcc_pkg::RESP_OKAY;
            d.rdata = 8'h00;
            case (araddr)
                adcc_pkg::ADDR_SC1: d.rdata = {q.conversion_complete_flag, q.complete_irq_enable, q.cont, q.chan};
                adcc_pkg::ADDR_SC2: d.rdata = {q.st == adcc_pkg::ST_CONV, q.trg,
                    q.cmp_en, q.cmp_gt, 4'h0};
                adcc_pkg::ADDR_RES_HIGH: d.rdata = {6'h00, q.result[adcc_pkg::RES_W-1:8]};
                adcc_pkg::ADDR_RES_LOW: begin
                    d.rdata = q.result[7:0];
                    conversion_complete_flag_clr = 1'b1;
                end
                adcc_pkg::ADDR_CMP_HIGH: d.rdata = {6'h00, q.cmp_val[adcc_pkg::RES_W-1:8]};
                adcc_pkg::ADDR_CMP_LOW: d.rdata = q.cmp_val[7:0];
                adcc_pkg::ADDR_IRQ_STATUS: d.rdata = {6'h00, q.irq_stat};
                adcc_pkg::ADDR_IRQ_MASK: d.rdata = {6'h00, q.irq_mask};
                default: d.rresp = adcc_pkg::RESP_SLVERR;
            endcase
        end

        // Completion flag, set wins over clear
        d.conversion_complete_flag = (q.conversion_complete_flag & ~conversion_complete_flag_clr) | conversion_complete_flag_set;
        d.conv_irq = d.conversion_complete_flag & d.complete_irq_enable;

        // Sticky event bits, write one to clear
        irq_ev[adcc_pkg::IRQ_EV_COMPLETE] = conversion_complete_flag_set;
        irq_ev[adcc_pkg::IRQ_EV_ABORT] = abort_ev;
        d.irq_stat = (q.irq_stat & ~irq_w1c) | irq_ev;
        d.irq = |(d.irq_stat & d.irq_mask);

        if (!aresetn) begin
            d = '0;
            d.st = adcc_pkg::ST_IDLE;
            d.chan = adcc_pkg::CHAN_RESET;
            d.route = decode_chan(adcc_pkg::CHAN_RESET);
            d.result = adcc_pkg::RESULT_RESET;
            d.cmp_val = adcc_pkg::CMP_RESET;
            d.irq_mask = adcc_pkg::IRQ_MASK_RESET;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

endmodule // adcc_top

// ### sim/adcc_sva.sv
// Checker of the converter control block, bound to its top module
`timescale 1ns/100ps
module adcc_sva (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, low
    input wire logic [7:0] awaddr, // Write address
    input wire logic awvalid, // Address valid
    input wire logic awready, // Address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic wvalid, // Data valid
    input wire logic wready, // Data ready
    input wire logic [1:0] bresp, // Response
    input wire logic bvalid, // Response valid
    input wire logic bready, // Response ready
    input adcc_pkg::adcc_conv_res_t conv_res, // Core answer
    input adcc_pkg::adcc_conv_ctl_t conv_ctl, // Core commands
    input adcc_pkg::adcc_route_t route, // Routing
    input wire logic conv_irq // Completion irq
);
    logic [7:0] wa_q, wd_q;
    logic bv_q, hw_q, cont_q, wr_now, sc1_wr;
    // Write takes effect in the cycle bvalid rises
    assign wr_now = bvalid && !bv_q;
    assign sc1_wr = wr_now && wa_q == adcc_pkg::ADDR_SC1;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa_q <= 8'h00;
            wd_q <= 8'h00;
            bv_q <= 1'b0;
            hw_q <= 1'b0;
            cont_q <= 1'b0;
        end else begin
            bv_q <= bvalid;
            if (awvalid && awready) wa_q <= awaddr;
            if (wvalid && wready) wd_q <= wdata[7:0];
            if (wr_now && wa_q == adcc_pkg::ADDR_SC2) hw_q <= wd_q[6];
            if (sc1_wr) cont_q <= wd_q[5];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_sw_restart: assert property (
        sc1_wr |-> conv_ctl.start == (!hw_q && wd_q[4:0] != 5'h1f))
        else $error("restart wrong");
    chk_flag_clear: assert property (
        sc1_wr && !conv_res.done ##1 !conv_res.done |=> !conv_irq)
        else $error("irq kept");
    // A write executing at the done edge may restart, so it is left out
    chk_single_idle: assert property (
        conv_res.done && conv_ctl.power_en && !cont_q && !wr_now
        && !(!awready && !wready && !bvalid) |=> !conv_ctl.power_en)
        else $error("no low power");
    chk_cont_again: assert property (
        conv_res.done && conv_ctl.power_en && cont_q && !wr_now
        && !(!awready && !wready && !bvalid)
        |=> conv_ctl.start && conv_ctl.power_en)
        else $error("no restart");
    chk_active_start: assert property (
        conv_ctl.start |-> conv_ctl.power_en)
        else $error("start idle");
    chk_disable_iso: assert property (
        conv_ctl.channel == 5'h1f |-> route.isolate && route.inputs == 28'h0 && !conv_ctl.start)
        else $error("not isolated");
    chk_route_pick: assert property (
        conv_ctl.channel < 5'h1c |-> route.inputs == (28'h1 << conv_ctl.channel))
        else $error("bad route");
    chk_resp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("response dropped");
    cover property (sc1_wr && conv_ctl.start);
    cover property (conv_res.done && cont_q);
    cover property (conv_irq);
endmodule // adcc_sva
bind adcc_top adcc_sva i_sva (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wvalid,
    .wready, .bresp, .bvalid, .bready, .conv_res, .conv_ctl, .route, .conv_irq);

// ### sim/adc_conversion_control_bench.sv
// Self-checking bench of the converter control block
`timescale 1ns/100ps
module adc_conversion_control_bench;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hardware_trigger_input, conv_irq, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    adcc_pkg::adcc_conv_res_t conv_res;
    adcc_pkg::adcc_conv_ctl_t conv_ctl;
    adcc_pkg::adcc_route_t route;
    int num_errors = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_abort = 0;
    logic [1:0] last_bresp;
    int cycles = 0;
    adcc_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .hardware_trigger_input, .conv_res, .conv_ctl, .route, .conv_irq,
        .irq);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Start counter and run limit
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (conv_ctl.start === 1'b1) n_start <= n_start + 1;
        if (conv_ctl.abort === 1'b1) n_abort <= n_abort + 1;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb) last_bresp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
        @(negedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
        @(negedge aclk);
    endtask
    task automatic rck(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, e, d);
    endtask
    task automatic fin(input logic [9:0] d);
        @(posedge aclk);
        conv_res <= {1'b1, d};
        @(posedge aclk);
        conv_res.done <= 1'b0;
        step(1);
    endtask
    task automatic t_single();
        logic [31:0] d;
        logic [1:0] r;
        rck(adcc_pkg::ADDR_SC1, 32'h1f, "sc1 reset");
        rd(8'h20, d, r);
        chk("unmapped", adcc_pkg::RESP_SLVERR, r);
        wr(8'h20, 8'h00);
        chk("unmapped wr", adcc_pkg::RESP_SLVERR, last_bresp);
        wr(adcc_pkg::ADDR_IRQ_MASK, 8'h01);
        chk("wr okay", adcc_pkg::RESP_OKAY, last_bresp);
        wr(adcc_pkg::ADDR_SC1, 8'hc3);
        chk("route", 28'h8, route.inputs);
        rck(adcc_pkg::ADDR_SC2, 32'h80, "active");
        rck(adcc_pkg::ADDR_SC1, 32'h43, "flag ro");
        fin(10'h155);
        rck(adcc_pkg::ADDR_SC1, 32'hc3, "flag");
        chk("conv irq", 1, conv_irq);
        chk("power", 0, conv_ctl.power_en);
        chk("starts", 1, n_start);
        rck(adcc_pkg::ADDR_RES_HIGH, 32'h1, "res high");
        chk("irq", 1, irq);
        wr(adcc_pkg::ADDR_IRQ_MASK, 8'h00);
        chk("irq masked", 0, irq);
        rck(adcc_pkg::ADDR_RES_LOW, 32'h55, "res low");
        rck(adcc_pkg::ADDR_SC1, 32'h43, "flag clr");
        chk("irq drop", 0, conv_irq);
        wr(adcc_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(adcc_pkg::ADDR_IRQ_MASK, 8'h01);
        chk("irq clr", 0, irq);
    endtask
    task automatic t_compare();
        logic [9:0] d;
        logic gt, e;
        logic [7:0] lo;
        lo = 8'h55;
        wr(adcc_pkg::ADDR_CMP_LOW, 8'h80);
        for (int i = 0; i < 4; i++) begin
            gt = (i < 2);
            d = i[0] ? 10'h080 : 10'h07f;
            e = gt ? (d >= 10'h080) : (d < 10'h080);
            if (e) lo = d[7:0];
            wr(adcc_pkg::ADDR_SC2, {2'h0, 1'b1, gt, 4'h0});
            wr(adcc_pkg::ADDR_SC1, 8'h05);
            fin(d);
            rck(adcc_pkg::ADDR_SC1, {24'h0, e, 7'h05}, "cmp flag");
            rck(adcc_pkg::ADDR_RES_LOW, lo, "cmp result");
        end
        wr(adcc_pkg::ADDR_SC2, 8'h00);
    endtask
    task automatic t_sweep();
        int n0, a0;
        n0 = n_start;
        a0 = n_abort;
        for (int c = 0; c < 32; c++) begin
            wr(adcc_pkg::ADDR_SC1, 8'(c));
            chk("route", c < 28 ? 32'h8 << c : {29'h0, c == 29, c == 30, c == 28 || c == 31},
                route);
        end
        chk("sweep starts", n0 + 31, n_start);
        chk("sweep aborts", a0 + 31, n_abort);
    endtask
    task automatic t_cont();
        int n0, a0;
        n0 = n_start;
        a0 = n_abort;
        wr(adcc_pkg::ADDR_SC1, 8'h3d);
        chk("high ref", 1, route.high_ref);
        fin(10'h003);
        chk("cont again", n0 + 2, n_start);
        chk("cont power", 1, conv_ctl.power_en);
        wr(adcc_pkg::ADDR_SC1, 8'h1f);
        chk("off", 0, conv_ctl.power_en);
        chk("stop abort", a0 + 1, n_abort);
        rck(adcc_pkg::ADDR_SC1, 32'h1f, "stop flag");
        step(10);
        chk("no more", n0 + 2, n_start);
    endtask
    task automatic t_hw();
        int n0;
        wr(adcc_pkg::ADDR_SC2, 8'h40);
        n0 = n_start;
        wr(adcc_pkg::ADDR_SC1, 8'h02);
        step(6);
        chk("hw no sw", n0, n_start);
        @(posedge aclk);
        hardware_trigger_input <= 1'b1;
        step(3);
        @(posedge aclk);
        hardware_trigger_input <= 1'b0;
        step(4);
        chk("hw start", n0 + 1, n_start);
        rck(adcc_pkg::ADDR_SC2, 32'hc0, "hw active");
        fin(10'h000);
        rck(adcc_pkg::ADDR_SC2, 32'h40, "hw idle");
        chk("hw single", n0 + 1, n_start);
    endtask
    initial begin
        {aresetn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
        hardware_trigger_input = 1'b0;
        conv_res = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        step(1);
        t_single();
        t_compare();
        t_sweep();
        t_cont();
        t_hw();
        complete_run();
    end
endmodule // adc_conversion_control_bench
